// ==== hdl/adsi_pkg.sv ====
// constants, types and helpers shared by the serial conversion interface
// Behaviour
// - differential: low select bits pick pair, top select bit swaps polarity
// - result frame: one zero, ten bits, two sub-LSB bits, three zeros
// - unipolar gives straight binary, bipolar gives two's complement
// - output bits change on falling serial clock, MSB first
// - track/hold samples while last three config bits shift in
// - two mode bits choose serial-clock or internal-oscillator conversion
// - external mode: serial clock also steps the approximation
// - external mode: strobe high one serial period after last config bit
// - external mode: decisions appear on data out over next 12 falling edges
// - external mode: strobe and data float while deselected, strobe low after select
// - internal mode: oscillator converts; result readable at any serial rate
// - internal mode: strobe low during conversion, at most 7.5us
// - internal mode: result held; first fall after strobe rises gives MSB
// - deselect during internal conversion floats data, conversion keeps running
// - internal mode: strobe always driven, never floats
// - data sampled on rising edges while selected; first one starts config byte
// - mode bits: 00 full down, 01 fast down, 10 internal, 11 external
// - conversion starts on falling edge after eighth config bit
package adsi_pkg;

  localparam int CFG_BITS      = 8;
  localparam int SAR_BITS      = 12;
  localparam int CFG_SEL_CNT   = 4;
  localparam int CFG_TRACK_CNT = 5;
  localparam int CFG_POL_CNT   = 6;

  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_INT_CLK = 2'h2;
  localparam logic [1:0] MODE_EXT_CLK = 2'h3;

  // synchroniser lanes
  localparam int SY_W    = 5;
  localparam int SY_CS   = 0;
  localparam int SY_SCLK = 1;
  localparam int SY_DIN  = 2;
  localparam int SY_HARD_POWERDOWN_PIN = 3;
  localparam int SY_CMP  = 4;
  localparam logic [SY_W-1:0] SY_RST = 5'h09;

  localparam int MCLK_PERIOD_NS   = 5;
  localparam int STRB_LOW_MAX_NS  = 7500;
  localparam int STRB_LOW_MAX_CYC = STRB_LOW_MAX_NS / MCLK_PERIOD_NS;
  // one spare step keeps the whole conversion inside the limit
  localparam int OSC_STEP_CYC     = STRB_LOW_MAX_CYC / (SAR_BITS + 1);

  localparam logic RST_CLK_EXT = 1'b0;
  localparam logic RST_STROBE  = 1'b1;

  typedef enum logic [1:0] {FR_HUNT, FR_SHIFT, FR_ARMED, FR_EXT} adsi_frame_type;

  // positive input channel from the three select bits
  function automatic logic [2:0] adsi_pos_ch(input logic [2:0] sel);
    return {sel[1:0], sel[2]};
  endfunction

endpackage

// ==== hdl/adsi_link_if.sv ====
// carrier between the synchroniser, the approximation engine and the top
`timescale 1ns/1ps
interface adsi_link_if;
  import adsi_pkg::*;
  logic [SY_W-1:0]     lvl;
  logic [SY_W-1:0]     rise;
  logic [SY_W-1:0]     fall;
  logic                start;
  logic                abort;
  logic                use_osc;
  logic                step_ext;
  logic                step_bit;
  logic                cmp;
  logic                busy;
  logic                done;
  logic [SAR_BITS-1:0] trial;

  modport sync_mp (output lvl, rise, fall);
  modport sar_mp  (input start, abort, use_osc, step_ext, step_bit, cmp,
                   output busy, done, trial);
  modport top_mp  (input lvl, rise, fall, busy, done, trial,
                   output start, abort, use_osc, step_ext, step_bit, cmp);
endinterface

// ==== hdl/adsi_sync.sv ====
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module adsi_sync #(
  parameter int                 W   = adsi_pkg::SY_W,
  parameter logic [W-1:0]       RST = adsi_pkg::SY_RST
) (
  input  wire logic         i_mclk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_raw,
  adsi_link_if.sync_mp      lnk
);
  import adsi_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } adsi_sync_state_type;

  adsi_sync_state_type st_ff;
  adsi_sync_state_type nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = i_raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '{s1: RST, s2: RST, s3: RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // edges look only at the second and third stages
  assign lnk.lvl  = st_ff.s2;
  assign lnk.rise = st_ff.s2 & ~st_ff.s3;
  assign lnk.fall = ~st_ff.s2 & st_ff.s3;
endmodule

// ==== hdl/adsi_sar.sv ====
// successive-approximation engine, stepped by serial clock or oscillator
`timescale 1ns/1ps
module adsi_sar #(
  parameter int STEP_CYC = adsi_pkg::OSC_STEP_CYC
) (
  input  wire logic    i_mclk,
  input  wire logic    i_arst_n,
  adsi_link_if.sar_mp  lnk
);
  import adsi_pkg::*;

  localparam int TW = $clog2(STEP_CYC + 1);

  typedef struct packed {
    logic                busy;
    logic                done;
    logic [3:0]          idx;
    logic [TW-1:0]       tick;
    logic [SAR_BITS-1:0] trial;
  } adsi_sar_state_type;

  adsi_sar_state_type st_ff;
  adsi_sar_state_type nxt_st;
  logic               step;
  logic               bit_val;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    step        = 1'b0;
    bit_val     = lnk.step_bit;
    if (lnk.use_osc) begin
      step    = st_ff.busy && (st_ff.tick == TW'(STEP_CYC - 1));
      bit_val = lnk.cmp;
    end else begin
      step = st_ff.busy && lnk.step_ext;
    end
    if (st_ff.busy) begin
      nxt_st.tick = step ? '0 : TW'(st_ff.tick + 1'b1);
    end
    if (step) begin
      nxt_st.trial[st_ff.idx] = bit_val;
      if (st_ff.idx == 4'h0) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.trial[st_ff.idx - 4'h1] = 1'b1;
        nxt_st.idx = 4'(st_ff.idx - 4'h1);
      end
    end
    if (lnk.start) begin
      nxt_st.busy  = 1'b1;
      nxt_st.idx   = 4'(SAR_BITS - 1);
      nxt_st.tick  = '0;
      nxt_st.trial = {1'b1, {(SAR_BITS-1){1'b0}}};
    end
    // an abort leaves the partial result; nobody reads it without done
    if (lnk.abort) begin
      nxt_st.busy = 1'b0;
      nxt_st.done = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lnk.busy  = st_ff.busy;
  assign lnk.done  = st_ff.done;
  assign lnk.trial = st_ff.trial;
endmodule

// ==== hdl/adsi_top.sv ====
// serial control and readout logic of the 8-channel converter
`timescale 1ns/1ps
module adsi_top #(
  parameter int STEP_CYC = adsi_pkg::OSC_STEP_CYC
) (
  input  wire logic                          i_mclk,
  input  wire logic                          i_arst_n,
  input  wire logic                          i_cs_n,
  input  wire logic                          i_sclk,
  input  wire logic                          i_din,
  input  wire logic                          i_hard_powerdown_pin_n,
  input  wire logic                          i_cmp_above,
  output logic                               o_dout,
  output logic                               o_dout_oe,
  output logic                               o_conversion_strobe_out,
  output logic                               o_conversion_strobe_oe,
  output logic [2:0]                         o_pos_ch,
  output logic [2:0]                         o_neg_ch,
  output logic                               o_neg_is_com,
  output logic                               o_bipolar,
  output logic                               o_track,
  output logic [adsi_pkg::SAR_BITS-1:0]      o_dac_code,
  output logic                               o_pd_full,
  output logic                               o_pd_fast,
  output logic                               o_busy
);
  import adsi_pkg::*;

  typedef struct packed {
    adsi_frame_type      frame;
    logic [3:0]          cnt;
    logic [7:0]          shreg;
    logic [1:0]          mode;
    logic [3:0]          fidx;
    logic                clk_ext;
    logic [2:0]          sel;
    logic                sgl;
    logic                bip;
    logic                pd_full_req;
    logic                pd_fast_req;
    logic                track;
    logic [SAR_BITS-1:0] rd_sh;
    logic                dout;
    logic                dout_oe;
    logic                strobe;
    logic                strobe_oe;
    logic                pd_full;
    logic                pd_fast;
    logic                start;
    logic                abort;
    logic                use_osc;
    logic                step_ext;
    logic                step_bit;
  } adsi_top_state_type;

  adsi_top_state_type st_ff;
  adsi_top_state_type nxt_st;
  logic               cs_n;
  logic               cs_rise;
  logic               sclk_rise;
  logic               sclk_fall;
  logic               din;
  logic               hard_powerdown_pin_n;
  logic               cmp;
  logic [7:0]         sh_new;
  logic [3:0]         cnt_new;
  logic [3:0]         fidx_new;
  logic               dec;

  adsi_link_if u_lnk ();

  adsi_sync u_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_raw    ({i_cmp_above, i_hard_powerdown_pin_n, i_din, i_sclk, i_cs_n}),
    .lnk      (u_lnk.sync_mp)
  );

  adsi_sar #(
    .STEP_CYC (STEP_CYC)
  ) u_sar (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .lnk      (u_lnk.sar_mp)
  );

  assign cs_n      = u_lnk.lvl[SY_CS];
  assign cs_rise   = u_lnk.rise[SY_CS];
  assign sclk_rise = u_lnk.rise[SY_SCLK];
  assign sclk_fall = u_lnk.fall[SY_SCLK];
  assign din       = u_lnk.lvl[SY_DIN];
  assign hard_powerdown_pin_n    = u_lnk.lvl[SY_HARD_POWERDOWN_PIN];
  assign cmp       = u_lnk.lvl[SY_CMP];

  assign u_lnk.start    = st_ff.start;
  assign u_lnk.abort    = st_ff.abort;
  assign u_lnk.use_osc  = st_ff.use_osc;
  assign u_lnk.step_ext = st_ff.step_ext;
  assign u_lnk.step_bit = st_ff.step_bit;
  assign u_lnk.cmp      = cmp;

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.start    = 1'b0;
    nxt_st.abort    = 1'b0;
    nxt_st.step_ext = 1'b0;
    sh_new          = {st_ff.shreg[6:0], din};
    cnt_new         = 4'(st_ff.cnt + 4'h1);
    fidx_new        = 4'(st_ff.fidx + 4'h1);
    // the first decision is the sign in bipolar mode
    dec             = cmp ^ (st_ff.bip && (st_ff.fidx == 4'h0));

    // internal conversion finished: hold the result for readout
    if (u_lnk.done && st_ff.use_osc) begin
      nxt_st.strobe = 1'b1;
      nxt_st.rd_sh  = {u_lnk.trial[SAR_BITS-1] ^ st_ff.bip,
                       u_lnk.trial[SAR_BITS-2:0]};
    end

    if (cs_rise) begin
      nxt_st.frame = FR_HUNT;
      nxt_st.cnt   = 4'h0;
      nxt_st.track = 1'b0;
      if (st_ff.clk_ext) begin
        nxt_st.strobe = 1'b0;
        if (st_ff.frame == FR_EXT) begin
          nxt_st.abort = 1'b1;
        end
      end
      // an internal conversion is left running here
    end else if (!cs_n && sclk_rise) begin
      case (st_ff.frame)
        FR_HUNT: begin
          if (din) begin
            nxt_st.shreg = 8'h01;
            nxt_st.cnt   = 4'h1;
            nxt_st.frame = FR_SHIFT;
          end
        end
        FR_SHIFT: begin
          nxt_st.shreg = sh_new;
          nxt_st.cnt   = cnt_new;
          if (cnt_new == 4'(CFG_SEL_CNT)) begin
            nxt_st.sel = sh_new[2:0];
          end
          if (cnt_new == 4'(CFG_TRACK_CNT)) begin
            nxt_st.track = 1'b1;
          end
          if (cnt_new == 4'(CFG_POL_CNT)) begin
            nxt_st.bip = ~sh_new[1];
            nxt_st.sgl = sh_new[0];
          end
          if (cnt_new == 4'(CFG_BITS)) begin
            nxt_st.mode  = sh_new[1:0];
            nxt_st.frame = FR_ARMED;
          end
        end
        default: begin
        end
      endcase
    end else if (!cs_n && sclk_fall) begin
      case (st_ff.frame)
        FR_ARMED: begin
          nxt_st.track = 1'b0;
          nxt_st.frame = FR_HUNT;
          nxt_st.dout  = 1'b0;
          case (st_ff.mode)
            MODE_EXT_CLK: begin
              nxt_st.start       = 1'b1;
              nxt_st.clk_ext     = 1'b1;
              nxt_st.use_osc     = 1'b0;
              nxt_st.strobe      = 1'b1;
              nxt_st.fidx        = 4'h0;
              nxt_st.frame       = FR_EXT;
              nxt_st.rd_sh       = '0;
              nxt_st.pd_full_req = 1'b0;
              nxt_st.pd_fast_req = 1'b0;
            end
            MODE_INT_CLK: begin
              nxt_st.start       = 1'b1;
              nxt_st.clk_ext     = 1'b0;
              nxt_st.use_osc     = 1'b1;
              nxt_st.strobe      = 1'b0;
              nxt_st.rd_sh       = '0;
              nxt_st.pd_full_req = 1'b0;
              nxt_st.pd_fast_req = 1'b0;
            end
            // power-down keeps the last clock mode for any running conversion
            default: begin
              nxt_st.pd_full_req = (st_ff.mode == MODE_FULL_PD);
              nxt_st.pd_fast_req = (st_ff.mode == MODE_FAST_PD);
            end
          endcase
        end
        FR_EXT: begin
          nxt_st.strobe   = 1'b0;
          nxt_st.fidx     = fidx_new;
          nxt_st.step_ext = 1'b1;
          // the engine keeps offset binary; only the pin sees the sign flip
          nxt_st.step_bit = cmp;
          nxt_st.dout     = dec;
          if (fidx_new == 4'(SAR_BITS)) begin
            nxt_st.frame = FR_HUNT;
          end
        end
        default: begin
          // zeros fill every slot without a result bit
          nxt_st.dout  = st_ff.rd_sh[SAR_BITS-1];
          nxt_st.rd_sh = {st_ff.rd_sh[SAR_BITS-2:0], 1'b0};
        end
      endcase
    end

    // the hard power-down pin overrides the software mode
    if (!hard_powerdown_pin_n && u_lnk.busy) begin
      nxt_st.abort = 1'b1;
      if (!st_ff.clk_ext) begin
        nxt_st.strobe = 1'b1;
      end
    end

    nxt_st.dout_oe   = !cs_n;
    nxt_st.strobe_oe = st_ff.clk_ext ? !cs_n : 1'b1;
    if (cs_n) begin
      nxt_st.dout = 1'b0;
    end
    nxt_st.pd_full = !hard_powerdown_pin_n || (st_ff.pd_full_req && !u_lnk.busy);
    nxt_st.pd_fast = hard_powerdown_pin_n && st_ff.pd_fast_req && !u_lnk.busy;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff           <= '0;
      st_ff.frame     <= FR_HUNT;
      st_ff.clk_ext   <= RST_CLK_EXT;
      st_ff.use_osc   <= ~RST_CLK_EXT;
      st_ff.mode      <= MODE_INT_CLK;
      st_ff.strobe    <= RST_STROBE;
      st_ff.strobe_oe <= 1'b1;
      st_ff.sgl       <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_dout                  = st_ff.dout;
  assign o_dout_oe               = st_ff.dout_oe;
  assign o_conversion_strobe_out = st_ff.strobe;
  assign o_conversion_strobe_oe  = st_ff.strobe_oe;
  assign o_pos_ch                = adsi_pos_ch(st_ff.sel);
  assign o_neg_ch                = adsi_pos_ch(st_ff.sel ^ 3'h4);
  assign o_neg_is_com            = st_ff.sgl;
  assign o_bipolar               = st_ff.bip;
  assign o_track                 = st_ff.track;
  assign o_dac_code              = u_lnk.trial;
  assign o_pd_full               = st_ff.pd_full;
  assign o_pd_fast               = st_ff.pd_fast;
  assign o_busy                  = u_lnk.busy;
endmodule

// ==== verification/adsi_top_checker.sv ====
// assertion checker for the serial conversion interface top
`timescale 1ns/1ps
module adsi_top_checker #(
  parameter int STEP_CYC = adsi_pkg::OSC_STEP_CYC
) (
  input wire logic       i_mclk,
  input wire logic       i_arst_n,
  input wire logic       i_cs_n,
  input wire logic       o_dout,
  input wire logic       o_dout_oe,
  input wire logic       o_conversion_strobe_out,
  input wire logic       o_conversion_strobe_oe,
  input wire logic [2:0] o_pos_ch,
  input wire logic [2:0] o_neg_ch,
  input wire logic       o_neg_is_com,
  input wire logic       o_track,
  input wire logic       o_pd_full,
  input wire logic       o_pd_fast,
  input wire logic       o_busy
);
  localparam int LIM = 12 * STEP_CYC + 8;
  logic        int_run_ff;
  logic        mode_int_ff;
  logic        mode_ok_ff;
  logic [15:0] low_cnt_ff;
  // mode of the last started conversion; a power-down byte leaves it unknown
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_run_ff  <= 1'b0;
      mode_int_ff <= 1'b1;
      mode_ok_ff  <= 1'b1;
      low_cnt_ff  <= 16'h0000;
    end else begin
      if ($rose(o_busy)) begin
        int_run_ff  <= !o_conversion_strobe_out;
        mode_int_ff <= !o_conversion_strobe_out;
        mode_ok_ff  <= 1'b1;
      end else if (!o_busy) begin
        int_run_ff <= 1'b0;
      end
      if (o_pd_full || o_pd_fast) begin
        mode_ok_ff <= 1'b0;
      end
      low_cnt_ff <= (int_run_ff && !o_conversion_strobe_out) ? low_cnt_ff + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  sequence ext_start;
    $rose(o_busy) && o_conversion_strobe_out;
  endsequence
  sequence cs_up;
    $rose(i_cs_n) && mode_ok_ff;
  endsequence
  chk_pair_neg: assert property (!o_neg_is_com |-> o_neg_ch == (o_pos_ch ^ 3'h1))
    else $error("differential pair mismatch");
  chk_ext_strobe_pulse: assert property (ext_start |-> o_conversion_strobe_out[*8]
    ##[1:6] !o_conversion_strobe_out) else $error("external strobe pulse wrong");
  chk_int_strobe_up: assert property ($fell(o_busy) && int_run_ff
    |-> ##[0:2] o_conversion_strobe_out) else $error("internal strobe not back high");
  chk_int_strobe_max: assert property (low_cnt_ff <= LIM)
    else $error("internal strobe low too long");
  chk_track_hold: assert property ($rose(o_track) |-> o_track[*8])
    else $error("track window too short");
  chk_track_start: assert property ($rose(o_busy) |-> $past(o_track, 1)
    || $past(o_track, 2) || $past(o_track, 3)) else $error("conversion without tracking");
  chk_dout_release: assert property ($rose(i_cs_n) |-> ##[1:5] (!o_dout_oe && !o_dout))
    else $error("data out not released");
  chk_strobe_float: assert property (cs_up and !mode_int_ff
    |-> ##[1:5] !o_conversion_strobe_oe) else $error("external strobe still driven");
  chk_strobe_kept_int: assert property (cs_up and mode_int_ff
    |-> o_conversion_strobe_oe[*8]) else $error("internal strobe released");
  chk_select_zero: assert property ($fell(i_cs_n) |-> ##[1:5] (o_dout_oe && !o_dout))
    else $error("data out not zero after select");
endmodule

bind adsi_top adsi_top_checker #(.STEP_CYC(STEP_CYC)) i_chk (.i_mclk, .i_arst_n, .i_cs_n,
  .o_dout, .o_dout_oe, .o_conversion_strobe_out, .o_conversion_strobe_oe, .o_pos_ch,
  .o_neg_ch, .o_neg_is_com, .o_track, .o_pd_full, .o_pd_fast, .o_busy);

// ==== verification/adsi_host_model.sv ====
// host serial master: select, serial clock and data in
`timescale 1ns/1ps
module adsi_host_model (
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_din,
  input  wire logic i_dout,
  input  wire logic i_dout_oe,
  input  wire logic i_strobe
);
  localparam realtime HALF = 32.0;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din  = 1'b0;
  end
  task automatic xfer_bit(input logic b, output logic r);
    o_din = b;
    #(HALF);
    o_sclk = 1'b1;
    r = i_dout_oe ? i_dout : 1'bx;
    #(HALF);
    o_sclk = 1'b0;
  endtask
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) xfer_bit(tx[i], rx[i]);
  endtask
  // odd offset keeps link edges off the system clock edges
  task automatic select();
    #0.3;
    o_cs_n = 1'b0;
    #(HALF);
  endtask
  // a released data line is flipped so a stale level never reads as data
  task automatic deselect();
    #(2 * HALF);
    o_cs_n = 1'b1;
    o_din  = ~o_din;
    #(2 * HALF);
  endtask
  task automatic frame(input logic [7:0] cfg, input int lead, input logic drop,
                       output logic [15:0] res);
    logic       junk;
    logic [7:0] rb1;
    res = 16'h0000;
    select();
    for (int i = 0; i < lead; i++) xfer_bit(1'b0, junk);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(cfg[i], rb1[i]);
      // a pause after the fifth bit stretches tracking in internal-clock frames
      if (i == 3 && cfg[1:0] == 2'b10) #(1600.0);
    end
    if (cfg[1:0] == 2'b10) begin
      // select stays low through the fall that starts the conversion
      #(HALF);
      o_cs_n = drop;
      #(HALF);
      for (int i = 0; i < 400 && !i_strobe; i++) #5;
      o_cs_n = 1'b0;
      #(HALF);
    end
    if (cfg[1]) begin
      xfer_byte(8'h00, res[15:8]);
      xfer_byte(8'h00, res[7:0]);
    end
    deselect();
  endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the serial conversion interface
`timescale 1ns/1ps
module tb_top;
  import adsi_pkg::*;
  localparam int STEP = 4;
  typedef struct packed {
    logic [7:0]  cfg;
    logic [3:0]  lead;
    logic        drop;
    logic [12:0] vin;
    logic [2:0]  pos;
    logic [2:0]  neg;
    logic        com;
    logic        bip;
    logic [15:0] frame;
  } adsi_row_type;
  // analog level is a half-step code so the comparator never meets a tie
  adsi_row_type rows [4] = '{
    '{8'h8F, 4'h0, 1'b0, 13'h1555, 3'h0, 3'h1, 1'b1, 1'b0, 16'h5550},
    '{8'hD3, 4'h3, 1'b0, 13'h0FFF, 3'h3, 3'h2, 1'b0, 1'b1, 16'h7FF8},
    '{8'hAA, 4'h0, 1'b0, 13'h0003, 3'h4, 3'h5, 1'b0, 1'b0, 16'h0008},
    '{8'hF6, 4'h1, 1'b1, 13'h1801, 3'h7, 3'h6, 1'b1, 1'b1, 16'h2000}};
  logic        i_mclk, i_arst_n, i_cs_n, i_sclk, i_din, i_hard_powerdown_pin_n;
  logic        o_dout, o_dout_oe, o_conversion_strobe_out, o_conversion_strobe_oe;
  logic        o_neg_is_com, o_bipolar, o_track, o_pd_full, o_pd_fast, o_busy, bitv;
  logic [2:0]  o_pos_ch, o_neg_ch;
  logic [11:0] o_dac_code;
  logic [12:0] vin;
  logic [15:0] got;
  wire logic   i_cmp_above = ({o_dac_code, 1'b0} < vin);
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;

  adsi_top #(.STEP_CYC(STEP)) i_dut (.i_mclk, .i_arst_n, .i_cs_n, .i_sclk, .i_din,
    .i_hard_powerdown_pin_n, .i_cmp_above, .o_dout, .o_dout_oe, .o_conversion_strobe_out,
    .o_conversion_strobe_oe, .o_pos_ch, .o_neg_ch, .o_neg_is_com, .o_bipolar, .o_track,
    .o_dac_code, .o_pd_full, .o_pd_fast, .o_busy);
  adsi_host_model i_host (.o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_din(i_din), .i_dout(o_dout),
    .i_dout_oe(o_dout_oe), .i_strobe(o_conversion_strobe_oe ? o_conversion_strobe_out : 1'bx));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic seen);
    chk_word(what, {15'h0000, exp}, {15'h0000, seen});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic do_reset();
    settle(1);
    i_arst_n = 1'b0;
    settle(6);
    i_arst_n = 1'b1;
    settle(2);
    chk_bit("strobe", 1'b1, o_conversion_strobe_out);
    chk_bit("strobe_oe", 1'b1, o_conversion_strobe_oe);
    chk_bit("dout_oe", 1'b0, o_dout_oe);
    chk_bit("busy", 1'b0, o_busy);
  endtask
  task automatic run_row(input adsi_row_type r);
    settle(1);
    vin = r.vin;
    i_host.frame(r.cfg, int'(r.lead), r.drop, got);
    settle(1);
    chk_word("frame", r.frame, got);
    chk_word("pos", {13'h0000, r.pos}, {13'h0000, o_pos_ch});
    chk_word("neg", {13'h0000, r.neg}, {13'h0000, o_neg_ch});
    chk_bit("single", r.com, o_neg_is_com);
    chk_bit("bipolar", r.bip, o_bipolar);
    chk_bit("strobe_oe", !r.cfg[0], o_conversion_strobe_oe);
    chk_bit("busy", 1'b0, o_busy);
  endtask

  initial begin
    i_arst_n = 1'b0;
    i_hard_powerdown_pin_n = 1'b1;
    vin = 13'h0000;
    do_reset();
    foreach (rows[i]) run_row(rows[i]);
    // a cut-off byte must leave nothing behind for the next frame
    settle(1);
    i_host.select();
    for (int i = 0; i < 4; i++) i_host.xfer_bit(1'b1, bitv);
    i_host.deselect();
    run_row(rows[0]);
    i_host.frame(8'h81, 0, 1'b0, got);
    settle(1);
    chk_bit("pd_fast", 1'b1, o_pd_fast);
    chk_bit("busy", 1'b0, o_busy);
    chk_bit("pd_full", 1'b0, o_pd_full);
    // the hard pin overrides the software fast power-down
    i_hard_powerdown_pin_n = 1'b0;
    settle(8);
    chk_bit("pd_hard", 1'b1, o_pd_full);
    chk_bit("pd_fast", 1'b0, o_pd_fast);
    i_hard_powerdown_pin_n = 1'b1;
    settle(8);
    i_host.frame(8'h80, 0, 1'b0, got);
    settle(1);
    chk_bit("pd_full", 1'b1, o_pd_full);
    chk_bit("pd_fast", 1'b0, o_pd_fast);
    do_reset();
    run_row(rows[1]);
    final_report();
  end
endmodule
